// File: hdl/lsd_driver.v
// Segment LCD driver: Avalon-MM register slave, display RAM, scan and drive level encoder
// Summary of operation
// R01: Pump clock code picks slow clock divide
// R02: Pump register bit 3 enables panel power
// R03: Software powers pump before display on
// R04: Two RAM bytes per common line
// R05: RAM bit n drives segment line n
// R06: Software initialises display RAM before use
// R07: Scan clock code picks divide 512..16
// R08: Scan clock resets to divide by 128
// R09: Mode field off, RAM, all zero, all one
// R10: Scan clock comes only from slow divider
// R11: Frame rate is scan rate over duty
// R12: Duty mask option two to four commons
// R13: Bias mask option half or third
// R14: Third bias uses four levels, half three
// R15: Highest used segment mask option zero to fifteen
// R16: Duty two forces half bias
// R17: RAM changes show at once, within the current scan step
// R18: Commons scanned ascending, wrap at duty
`timescale 1ns/1ps
`default_nettype none
`include "lsd_map.vh"
module lsd_driver
(
  input  wire        clk,
  input  wire        rst,
  input  wire [11:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        slow_clk_in,
  output reg         pump_clk,
  output reg         panel_power_en,
  output reg  [7:0]  common_line_lvl,
  output reg  [31:0] segment_line_lvl
);

  // Effective bias: duty two allows only half bias
  localparam BIAS3 = (`LSD_DUTY > 3'h2) ? `LSD_BIAS_THIRD : 1'b0; // R16 R13

  // Bus handshake state
  reg         ack_q;
  reg  [3:0]  pump_q;
  reg  [4:0]  disp_q;
  reg  [7:0]  ram_q [0:7];
  wire        req;
  wire [9:0]  idx;
  wire        aligned;
  wire        hit_ram;
  wire [2:0]  ram_idx;
  reg  [31:0] rd_d;
  wire        hit_pump;
  wire        hit_disp;
  wire        hit_stat;
  wire        wr_done;

  // Slow clock path
  reg         s1_q;
  reg         s2_q;
  reg         s3_q;
  reg         slow_lvl_q;
  wire        slow_rise;
  reg  [`LSD_DIV_W-1:0] div_q;
  reg         pump_tap;
  reg         scan_tap;
  reg         scan_tap_q;
  wire        scan_tick;

  // Scan state
  reg  [1:0]  com_idx_q;
  reg         phase_q;
  wire        com_wrap;

  // Drive level next values
  reg  [7:0]  com_lvl_d;
  wire [31:0] seg_lvl_d;
  wire [15:0] seg_row;
  wire [1:0]  mode;
  integer     c;

  assign req     = avs_read | avs_write;
  assign idx     = avs_address[11:2];
  assign aligned = (avs_address[1:0] == 2'b00);
  // RAM window: commons at 0x200, 0x208, 0x210, 0x218, low then high byte
  assign hit_ram = aligned && (idx[9:5] == `LSD_IDX_RAM_TOP) && (idx[2:1] == 2'b00); // R04
  assign ram_idx = {idx[4:3], idx[0]}; // R04

  // Control and status decode; only whole-word aligned addresses match
  assign hit_pump = aligned && (idx == `LSD_IDX_PUMP);
  assign hit_disp = aligned && (idx == `LSD_IDX_DISP);
  assign hit_stat = aligned && (idx == `LSD_IDX_STAT);
  // A write lands only on the answer edge, and only for lane zero
  assign wr_done  = avs_write && ack_q && avs_byteenable[0];

  // One wait cycle, then the answer; the edge seeing waitrequest low completes
  assign avs_waitrequest = req & ~ack_q;

  // Read multiplexer; unmapped or misaligned reads return zero
  always @*
  begin
    rd_d = 32'h0;
    if (hit_ram)
      rd_d[7:0] = ram_q[ram_idx];
    else if (hit_pump)
      rd_d[3:0] = pump_q;
    else if (hit_disp)
      rd_d[4:0] = disp_q;
    else if (hit_stat)
      rd_d[2:0] = {phase_q, com_idx_q};
  end

  // Acknowledge and read data capture
  // Data are taken on the request edge, so they stand through the answer cycle
  always @(posedge clk)
  begin
    if (rst)
    begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q)
        avs_readdata <= rd_d;
    end
  end

  // Control registers; writes land on the completing edge only
  always @(posedge clk)
  begin
    if (rst)
    begin
      pump_q <= `LSD_PUMP_RST; // R01 R02
      disp_q <= `LSD_DISP_RST; // R08 R09
    end
    else if (wr_done)
    begin
      if (hit_pump)
        pump_q <= avs_writedata[3:0];
      if (hit_disp)
        disp_q <= avs_writedata[4:0];
    end
  end

  // Display RAM is left unreset: contents are undefined until written
  // Software must fill every byte before display on, since none is reset
  always @(posedge clk)
  begin
    if (wr_done && hit_ram)
      ram_q[ram_idx] <= avs_writedata[7:0]; // R17
  end

  // Slow clock crosses in by three flops; a change counts when two and three agree
  // Only the second flop reads the first, which may settle late
  always @(posedge clk)
  begin
    if (rst)
    begin
      s1_q       <= 1'b0;
      s2_q       <= 1'b0;
      s3_q       <= 1'b0;
      slow_lvl_q <= 1'b0;
    end
    else
    begin
      s1_q <= slow_clk_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        slow_lvl_q <= s3_q;
    end
  end

  assign slow_rise = (s2_q == s3_q) && s3_q && !slow_lvl_q;

  // Ripple divider: bit n toggles at slow rate over 2^(n+1)
  // Nine bits reach the slowest scan tap, the divide by 512
  always @(posedge clk)
  begin
    if (rst)
      div_q <= {`LSD_DIV_W{1'b0}};
    else if (slow_rise)
      div_q <= div_q + 1'b1; // R10
  end

  // Tap selectors: scan fed only from the slow divider, pump code 7 bypasses it
  // Code 7 passes the synchronised level, so its edges jitter by a fast cycle
  always @*
  begin
    if (pump_q[`LSD_PUMP_CLK_MSB:0] == `LSD_PUMP_UNDIV)
      pump_tap = slow_lvl_q; // R01
    else
      pump_tap = div_q[`LSD_TAP_PUMP_TOP - pump_q[`LSD_PUMP_CLK_MSB:0]]; // R01
    if (disp_q[`LSD_SCAN_MSB])
      scan_tap = div_q[`LSD_TAP_PUMP_TOP - disp_q[1:0]]; // R07 R10
    else
      scan_tap = div_q[`LSD_TAP_SCAN_LOW - disp_q[0]]; // R07
  end

  // Pump clock and power outputs
  // Power bit gates the pump clock: a disabled generator sees no edges
  always @(posedge clk)
  begin
    if (rst)
    begin
      pump_clk       <= 1'b0;
      panel_power_en <= 1'b0;
      scan_tap_q     <= 1'b0;
    end
    else
    begin
      panel_power_en <= pump_q[`LSD_PUMP_PWR_BIT]; // R02
      pump_clk       <= pump_q[`LSD_PUMP_PWR_BIT] & pump_tap; // R02
      scan_tap_q     <= scan_tap;
    end
  end

  // One common step per rising scan edge
  assign scan_tick = scan_tap & ~scan_tap_q;
  assign com_wrap  = ({1'b0, com_idx_q} == (`LSD_DUTY - 3'h1)); // R12

  // Common sequencer; phase flips each frame for AC drive
  // A scan code change may cut one step short; the ascending order still holds
  always @(posedge clk)
  begin
    if (rst)
    begin
      com_idx_q <= 2'h0;
      phase_q   <= 1'b0;
    end
    else if (scan_tick)
    begin
      if (com_wrap)
      begin
        com_idx_q <= 2'h0; // R18 R11
        phase_q   <= ~phase_q;
      end
      else
        com_idx_q <= com_idx_q + 2'h1; // R18
    end
  end

  // Mode field: off, RAM, all zero, all one
  assign mode    = disp_q[`LSD_MODE_MSB:`LSD_MODE_LSB];
  // Live RAM row of the active common; no shadow latch
  assign seg_row = {ram_q[{com_idx_q, 1'b1}], ram_q[{com_idx_q, 1'b0}]}; // R05 R17

  // Common levels: selected goes full swing, others sit at V1 or V2
  // Level codes: 0 ground, 1 and 2 middle levels, 3 full panel supply
  always @*
  begin
    com_lvl_d = 8'h0;
    for (c = 0; c < 4; c = c + 1)
    begin
      if (mode == `LSD_MODE_OFF || c >= `LSD_DUTY)
        com_lvl_d[2*c +: 2] = `LSD_LVL_VSS; // R09 R12
      else if (c == com_idx_q)
        com_lvl_d[2*c +: 2] = phase_q ? `LSD_LVL_VSS : `LSD_LVL_FULL;
      else if (BIAS3 && phase_q)
        com_lvl_d[2*c +: 2] = `LSD_LVL_V2; // R14
      else
        com_lvl_d[2*c +: 2] = `LSD_LVL_V1; // R14
    end
  end

  // Segment levels, one slice per segment line
  // A lit cell sees full swing against the scanned common, a dark one stays in the bias band
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_seg
      wire on;
      assign on = (mode == `LSD_MODE_ONE) | ((mode == `LSD_MODE_RAM) & seg_row[g]); // R09 R05
      // Unused lines and display off stay at ground
      assign seg_lvl_d[2*g +: 2] =
        (mode == `LSD_MODE_OFF || g > `LSD_SEG_OPT) ? `LSD_LVL_VSS : // R15 R09
        on ? (phase_q ? `LSD_LVL_FULL : `LSD_LVL_VSS) :
        BIAS3 ? (phase_q ? `LSD_LVL_V1 : `LSD_LVL_V2) : // R14
        (phase_q ? `LSD_LVL_VSS : `LSD_LVL_FULL); // R14
    end
  endgenerate

  // Registered drive outputs
  always @(posedge clk)
  begin
    if (rst)
    begin
      common_line_lvl  <= 8'h0;
      segment_line_lvl <= 32'h0;
    end
    else
    begin
      common_line_lvl  <= com_lvl_d;
      segment_line_lvl <= seg_lvl_d;
    end
  end

endmodule
`default_nettype wire

// File: hdl/lsd_map.vh
// Register map, field layout, reset values and mask options of the segment LCD driver
`ifndef LSD_MAP_VH
`define LSD_MAP_VH
// Register indices; byte address is four times the index
`define LSD_IDX_PUMP      10'h01a
`define LSD_IDX_DISP      10'h01b
`define LSD_IDX_STAT      10'h01d
`define LSD_IDX_RAM_TOP   5'h10
// Pump clock control fields
`define LSD_PUMP_CLK_MSB  2
`define LSD_PUMP_PWR_BIT  3
`define LSD_PUMP_RST      4'hf
`define LSD_PUMP_UNDIV    3'h7
// Display control fields
`define LSD_SCAN_MSB      2
`define LSD_MODE_LSB      3
`define LSD_MODE_MSB      4
`define LSD_DISP_RST      5'h04
`define LSD_MODE_OFF      2'h0
`define LSD_MODE_RAM      2'h1
`define LSD_MODE_ZERO     2'h2
`define LSD_MODE_ONE      2'h3
// Slow divider taps used by the selectors
`define LSD_TAP_PUMP_TOP  6
`define LSD_TAP_SCAN_LOW  8
`define LSD_DIV_W         9
// Mask options: duty 2..4, third bias flag, highest used segment 0..15
`define LSD_DUTY          3'h4
`define LSD_BIAS_THIRD    1'b1
`define LSD_SEG_OPT       4'hf
// Drive level codes
`define LSD_LVL_VSS       2'h0
`define LSD_LVL_V1        2'h1
`define LSD_LVL_V2        2'h2
`define LSD_LVL_FULL      2'h3
`endif

// File: tb/lsd_driver_asserts.sv
// Port checks for the segment LCD driver
`timescale 1ns/1ps
`default_nettype none
module lsd_driver_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pump_clk,
  input wire logic        panel_power_en,
  input wire logic [7:0]  common_line_lvl,
  input wire logic [31:0] segment_line_lvl
);
  // Commons at an extreme level, one bit per common
  wire  [7:0] sel = ~(common_line_lvl ^ (common_line_lvl >> 1)) & 8'h55;
  wire        full = |(common_line_lvl & (common_line_lvl >> 1) & 8'h55);
  wire        pw = avs_write && !avs_waitrequest && avs_address == 12'h068 && avs_byteenable[0];
  logic [7:0] sel_q;
  // Previous scanned common, for the step order
  always @(posedge clk)
    sel_q <= rst ? 8'h00 : sel;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait");
  chk_rd_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_pwr_write: assert property (pw |-> ##2 panel_power_en == $past(avs_writedata[3], 2))
    else $error("power enable not following write");
  chk_pump_gate: assert property (!panel_power_en [*2] |-> !pump_clk)
    else $error("pump clock runs with power off");
  chk_com_single: assert property (common_line_lvl != 8'h00 |-> $onehot(sel))
    else $error("not exactly one common scanned");
  chk_com_order: assert property (sel != sel_q && $onehot(sel_q) && $onehot(sel) |-> sel == {sel_q[5:0], sel_q[7:6]})
    else $error("common order broken");
  chk_seg_even: assert property (full |-> (segment_line_lvl & 32'h55555555) == 32'h0)
    else $error("segment level wrong in first phase");
  chk_seg_odd: assert property (common_line_lvl != 8'h00 && !full |-> &(segment_line_lvl | 32'haaaaaaaa))
    else $error("segment level wrong in second phase");
endmodule
bind lsd_driver lsd_driver_asserts chk (.*);
`default_nettype wire

// File: tb/lsd_driver_bench.sv
// Self-checking bench for the segment LCD driver
`timescale 1ns/1ps
`default_nettype none
module lsd_driver_bench;
  logic        clk, rst, avs_read, avs_write, slow_clk_in, avs_waitrequest;
  logic        pump_clk, panel_power_en, p_act, q, ph;
  logic [11:0] avs_address, a;
  logic [31:0] avs_writedata, avs_readdata, segment_line_lvl;
  logic [3:0]  avs_byteenable;
  logic [7:0]  common_line_lvl, d, ram [8], exp_q [$];
  logic [1:0]  p_idx, p_was;
  logic [15:0] p_lit;
  int          n_mismatch, total_checks, cyc, k;
  lsd_driver uut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .slow_clk_in, .pump_clk, .panel_power_en, .common_line_lvl,
    .segment_line_lvl);
  lsd_panel pnl (.common_line_lvl, .segment_line_lvl, .active(p_act), .com_idx(p_idx), .lit(p_lit));
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // Fast stand-in slow clock, period 8 cycles; hang limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3)
      slow_clk_in <= ~slow_clk_in;
    if (cyc == 80000)
    begin
      n_mismatch++;
      finish_test;
    end
  end
  // Each read result against the oldest note
  always @(negedge clk)
    if (avs_read && !avs_waitrequest)
      chk(exp_q.pop_front(), avs_readdata, "read");
  task automatic chk(logic [31:0] e, logic [31:0] s, string n);
    total_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic acc(bit w, logic [11:0] ad, logic [7:0] v, logic [7:0] e = 0, logic [3:0] be = 1);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= {24'h0, v};
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    if (!w)
      exp_q.push_back(e);
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 0;
    avs_write <= 0;
  endtask
  // Mode m at the fastest scan; each common checked after a fresh step
  task automatic show(logic [1:0] m);
    acc(1, 12'h06c, {3'h0, m, 3'h7});
    for (int c = -1; c < 4; c++)
    begin
      k = 0;
      do begin @(negedge clk); k++; end while (!(p_act === 1'b1 && p_idx == c[1:0]) && k < 9999);
      chk(1, k < 9999, "scan wait");
      // Phase seen on the last common; it must flip exactly at the wrap
      if (c < 0)
        ph = common_line_lvl[7:6] == 2'h0;
      else
      begin
        ph = ph ^ (c == 0);
        chk(m == 1 ? {ram[2*c+1], ram[2*c]} : {16{m[0]}}, p_lit, "lit");
        chk(ph, common_line_lvl[2*c +: 2] == 2'h0, "phase");
        acc(0, 12'h074, 0, {5'h0, ph, c[1:0]});
      end
    end
    $display("mode %0d done", m);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    {rst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, slow_clk_in, q} = {1'b1, 52'h0};
    repeat (10) @(posedge clk);
    rst <= 0;
    k = $urandom(86);
    // Reset values; unmapped, misaligned and masked places
    acc(1, 12'h070, 8'hff);
    acc(1, 12'h06c, 8'h1b, 0, 4'h0);
    acc(0, 12'h068, 0, 8'h0f);
    acc(0, 12'h06c, 0, 8'h04);
    acc(0, 12'h070, 0, 8'h00);
    acc(0, 12'h069, 0, 8'h00);
    // Random fields; display mode kept off until RAM is set
    for (int i = 0; i < 6; i++)
    begin
      a = i[0] ? 12'h06c : 12'h068;
      d = 8'($urandom) & (i[0] ? 8'he7 : 8'hff);
      acc(1, a, d);
      acc(0, a, 0, d & (i[0] ? 8'h07 : 8'h0f));
    end
    $display("registers done");
    // Pump rises over 256 slow periods, per code
    for (int c = 0; c < 8; c++)
    begin
      acc(1, 12'h068, 8'(8 + c));
      k = 0;
      repeat (2048)
      begin
        @(negedge clk);
        k += pump_clk && !q;
        q = pump_clk;
      end
      chk(1, k >= (256 >> (7 - c)) - 1 && k <= (256 >> (7 - c)) + 1, "pump rate");
    end
    acc(1, 12'h068, 8'h07);
    repeat (4) @(posedge clk);
    repeat (64) @(negedge clk) chk(0, {pump_clk, panel_power_en}, "power off");
    acc(1, 12'h068, 8'h0f);
    $display("pump done");
    // Every display byte written and read back before display on
    for (int i = 0; i < 8; i++)
    begin
      ram[i] = 8'($urandom);
      a = 12'(12'h800 + 32 * (i / 2) + 4 * (i % 2));
      acc(1, a, ram[i]);
      acc(0, a, 0, ram[i]);
    end
    $display("display ram done");
    show(1);
    ram[0] = ~ram[0];
    acc(1, 12'h800, ram[0]);
    show(1);
    show(2);
    show(3);
    // Step length for scan codes 2 to 7; third interval is clean of any switch glitch
    for (int c = 2; c < 8; c++)
    begin
      acc(1, 12'h06c, 8'(8 + c));
      for (int j = 0; j < 3; j++)
      begin
        k = 0;
        p_was = p_idx;
        do begin @(negedge clk); k++; end while (p_idx == p_was && k < 5000);
      end
      chk(8 * (c < 4 ? 512 >> c[0] : 128 >> (c - 4)), k, "scan step");
    end
    $display("scan done");
    acc(1, 12'h06c, 8'h07);
    repeat (300) @(posedge clk);
    chk(0, common_line_lvl | segment_line_lvl, "off");
    $display("off done");
    acc(1, 12'h068, 8'h07);
    finish_test;
  end
endmodule
`default_nettype wire

// File: tb/lsd_panel.sv
// Passive glass model: which cells see full swing on the scanned common
`timescale 1ns/1ps
`default_nettype none
module lsd_panel (
  input  wire logic [7:0]  common_line_lvl,
  input  wire logic [31:0] segment_line_lvl,
  output logic             active,
  output logic [1:0]       com_idx,
  output logic [15:0]      lit
);
  int n;
  // Scanned common is the one at an extreme level
  always_comb
  begin
    n = 0;
    com_idx = 2'h0;
    for (int c = 0; c < 4; c++)
      if (common_line_lvl[2*c] == common_line_lvl[2*c+1])
      begin
        n++;
        com_idx = c[1:0];
      end
    active = n == 1;
    for (int s = 0; s < 16; s++)
      lit[s] = segment_line_lvl[2*s +: 2] == ~common_line_lvl[2*com_idx +: 2];
  end
endmodule
`default_nettype wire
